// ==== common/fast_context_defs.vh ====
// Constants for the fast context, return stack and pc latch unit
`ifndef FAST_CONTEXT_DEFS_VH
`define FAST_CONTEXT_DEFS_VH

`define FC_REG_CTRL        8'h00
`define FC_REG_STACK       8'h04
`define FC_REG_IRQ_STATUS  8'h08
`define FC_REG_IRQ_CLEAR   8'h0C
`define FC_REG_IRQ_ENABLE  8'h10
`define FC_REG_PC          8'h14

`define FC_CTRL_STACK_ERROR_RESET_ENABLE_BIT 0
`define FC_CTRL_RESET      1'b1

`define FC_STK_FULL_BIT    0
`define FC_STK_UNDER_BIT   1
`define FC_STK_COUNT_LSB   8

`define FC_EV_FULL         0
`define FC_EV_UNDER        1
`define FC_EV_OVERWRITE    2
`define FC_EV_W            3
`define FC_EV_RESET        3'h0

`define FC_PC_W            21
`define FC_PC_RESET        21'h000000
`define FC_PC_STEP         21'h000002
`define FC_STATUS_W        8
`define FC_BSR_W           4

`endif

// ==== rtl/return_stack.v ====
// Return address stack with overflow and underflow detection
`timescale 1ns/1ps
`default_nettype none

module return_stack #(
  parameter            AW    = 21,
  parameter            CW    = 5,
  parameter [CW-1:0]   DEPTH = 5'h1F
) (
  input  wire          clk_sys,
  input  wire          clear,
  input  wire          push,
  input  wire          pop,
  input  wire [AW-1:0] push_data,
  output wire [AW-1:0] pop_data,
  output wire [CW-1:0] count,
  output wire          overflow,
  output wire          underflow
);

  reg  [AW-1:0] mem [0:DEPTH-1];
  reg  [CW-1:0] cnt_q;
  wire          empty;
  wire          full;
  wire [CW-1:0] top_idx;

  assign empty     = (cnt_q == {CW{1'b0}});
  assign full      = (cnt_q == DEPTH);
  assign top_idx   = cnt_q - {{(CW-1){1'b0}}, 1'b1};
  assign pop_data  = empty ? {AW{1'b0}} : mem[top_idx];
  assign count     = cnt_q;
  assign overflow  = push & full;
  assign underflow = pop & empty;

  // Push into a full stack is dropped; pop from empty yields zero
  always @(posedge clk_sys) begin
    if (clear) begin
      cnt_q <= {CW{1'b0}};
    end else if (push & ~full) begin
      mem[cnt_q] <= push_data;
      cnt_q      <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end else if (pop & ~empty) begin
      cnt_q <= top_idx;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/fast_context_unit.v ====
// Fast context shadow, return stack errors and pc latch unit
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fast_context_defs.vh"

// Contract
// [RULE_01] Reset enable set: flag then device reset
// [RULE_02] Reset enable clear: flag only, no reset
// [RULE_03] Flags cleared only by software or power-on
// [RULE_04] One hidden shadow per status, working, bank
// [RULE_05] Every interrupt vector loads all three shadows
// [RULE_06] Fast interrupt return restores all three registers
// [RULE_07] Nested interrupt overwrites the single shadow level
// [RULE_08] Fast call saves context and pushes return
// [RULE_09] Fast return restores context and pops address
// [RULE_10] Software computed jump offset is even
// [RULE_11] Add to pc low byte leaves latches
// [RULE_12] Reading pc low byte refreshes both latches
// [RULE_13] Literal return loads working register, pops address
// [RULE_14] Pc steps by two, bit zero zero
// [RULE_15] Shadows captured in the vector cycle itself
module fast_context_unit #(
  parameter SCW         = 5,
  parameter [SCW-1:0] STACK_DEPTH = 5'h1F
) (
  input  wire                    clk_sys,
  input  wire                    rst,
  input  wire                    soft_rst,
  input  wire                    wb_cyc_i,
  input  wire                    wb_stb_i,
  input  wire                    wb_we_i,
  input  wire [7:0]              wb_adr_i,
  input  wire [3:0]              wb_sel_i,
  input  wire [31:0]             wb_dat_i,
  output reg  [31:0]             wb_dat_o,
  output reg                     wb_ack_o,
  input  wire                    int_vector,
  input  wire [`FC_PC_W-1:0]     int_vector_addr,
  input  wire                    call_op,
  input  wire                    call_fast,
  input  wire [`FC_PC_W-1:0]     call_addr,
  input  wire                    return_op,
  input  wire                    return_fast,
  input  wire                    return_from_interrupt_op,
  input  wire                    return_from_interrupt_fast,
  input  wire                    return_with_literal_op,
  input  wire [7:0]              return_with_literal_literal,
  input  wire                    pc_step,
  input  wire                    pcl_read,
  input  wire                    pcl_add,
  input  wire [7:0]              pcl_add_offset,
  input  wire                    latch_high_we,
  input  wire                    latch_upper_we,
  input  wire [7:0]              latch_wd,
  input  wire                    working_register_we,
  input  wire [7:0]              working_register_wd,
  input  wire                    status_we,
  input  wire [`FC_STATUS_W-1:0] status_wd,
  input  wire                    bsr_we,
  input  wire [`FC_BSR_W-1:0]    bsr_wd,
  output reg  [`FC_PC_W-1:0]     pc_q,
  output reg  [7:0]              pc_high_latch_q,
  output reg  [4:0]              pc_upper_latch_q,
  output reg  [7:0]              working_register_q,
  output reg  [`FC_STATUS_W-1:0] status_q,
  output reg  [`FC_BSR_W-1:0]    bank_select_register_q,
  output reg                     stack_full_flag_q,
  output reg                     stack_underflow_flag_q,
  output reg                     stack_reset_q,
  output reg                     irq_q
);

  reg  [`FC_STATUS_W-1:0] shadow_status_q;
  reg  [7:0]              shadow_working_q;
  reg  [`FC_BSR_W-1:0]    shadow_bank_q;
  reg                     shadow_live_q;
  reg                     stack_error_reset_enable_q;
  reg  [`FC_EV_W-1:0]     irq_status_q;
  reg  [`FC_EV_W-1:0]     irq_enable_q;

  reg  [`FC_PC_W-1:0]     pc_d;
  reg  [`FC_EV_W-1:0]     irq_status_d;
  reg  [31:0]             rd_data;

  wire                    core_clear;
  wire                    wb_req;
  wire                    wb_wr;
  wire                    wb_rd_lo;
  wire                    do_save;
  wire                    do_restore;
  wire                    stk_push;
  wire                    stk_pop;
  wire [`FC_PC_W-1:0]     stk_top;
  wire [SCW-1:0]          stk_count;
  wire                    stk_over;
  wire                    stk_under;
  wire [7:0]              pcl_sum;
  wire [`FC_EV_W-1:0]     ev;
  wire                    full_clr;
  wire                    under_clr;

  // Other reset sources and the stack error reset clear the core state
  assign core_clear = soft_rst | stack_reset_q;

  assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign wb_rd_lo = wb_sel_i[0];

  // Any interrupt vector or fast call saves; fast returns restore
  assign do_save    = int_vector | (call_op & call_fast);    // [RULE_05] [RULE_08]
  assign do_restore = (return_from_interrupt_op & return_from_interrupt_fast) |
                      (return_op & return_fast);            // [RULE_06] [RULE_09]

  assign stk_push = int_vector | call_op;
  assign stk_pop  = ~int_vector & ~call_op &
                    (return_op | return_from_interrupt_op | return_with_literal_op);     // [RULE_13]

  return_stack #(
    .AW    (`FC_PC_W),
    .CW    (SCW),
    .DEPTH (STACK_DEPTH)
  ) u_return_stack (
    .clk_sys   (clk_sys),
    .clear     (rst | core_clear),
    .push      (stk_push),
    .pop       (stk_pop),
    .push_data (pc_q),
    .pop_data  (stk_top),
    .count     (stk_count),
    .overflow  (stk_over),
    .underflow (stk_under)
  );

  // Offset from software is even, bit zero is forced clear anyway
  assign pcl_sum = pc_q[7:0] + pcl_add_offset;               // [RULE_10]

  always @* begin
    pc_d = pc_q;
    if (int_vector) begin
      pc_d = int_vector_addr;
    end else if (call_op) begin
      pc_d = call_addr;
    end else if (stk_pop) begin
      pc_d = stk_top;
    end else if (pcl_add) begin
      pc_d = {pc_upper_latch_q, pc_high_latch_q, pcl_sum};
    end else if (pc_step) begin
      pc_d = pc_q + `FC_PC_STEP;                             // [RULE_14]
    end
    pc_d[0] = 1'b0;                                          // [RULE_14]
  end

  always @(posedge clk_sys) begin
    if (rst | core_clear) begin
      pc_q <= `FC_PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Latches follow software writes and pc low byte reads only
  always @(posedge clk_sys) begin
    if (rst | core_clear) begin
      pc_high_latch_q  <= 8'h00;
      pc_upper_latch_q <= 5'h00;
    end else if (pcl_read) begin
      pc_high_latch_q  <= pc_q[15:8];                        // [RULE_12]
      pc_upper_latch_q <= pc_q[20:16];                       // [RULE_12]
    end else begin
      if (latch_high_we) begin
        pc_high_latch_q <= latch_wd;
      end
      if (latch_upper_we) begin
        pc_upper_latch_q <= latch_wd[4:0];
      end
    end
    // No latch update on pcl_add                            // [RULE_11]
  end

  // Context registers; restore and literal load win over core writes
  always @(posedge clk_sys) begin
    if (rst | core_clear) begin
      working_register_q     <= 8'h00;
      status_q               <= {`FC_STATUS_W{1'b0}};
      bank_select_register_q <= {`FC_BSR_W{1'b0}};
    end else if (do_restore) begin
      working_register_q     <= shadow_working_q;           // [RULE_06]
      status_q               <= shadow_status_q;            // [RULE_09]
      bank_select_register_q <= shadow_bank_q;              // [RULE_06]
    end else begin
      if (return_with_literal_op) begin
        working_register_q <= return_with_literal_literal;                 // [RULE_13]
      end else if (working_register_we) begin
        working_register_q <= working_register_wd;
      end
      if (status_we) begin
        status_q <= status_wd;
      end
      if (bsr_we) begin
        bank_select_register_q <= bsr_wd;
      end
    end
  end

  // Hidden shadow level, loaded from the values held in the vector or fast call cycle
  always @(posedge clk_sys) begin
    if (rst | core_clear) begin
      shadow_status_q  <= {`FC_STATUS_W{1'b0}};
      shadow_working_q <= 8'h00;
      shadow_bank_q    <= {`FC_BSR_W{1'b0}};
      shadow_live_q    <= 1'b0;
    end else if (do_save) begin
      shadow_status_q  <= status_q;                          // [RULE_04] [RULE_15]
      shadow_working_q <= working_register_q;                // [RULE_15]
      shadow_bank_q    <= bank_select_register_q;            // [RULE_07]
      shadow_live_q    <= int_vector;
    end else if (do_restore) begin
      shadow_live_q <= 1'b0;
    end
  end

  // Events; a nested vector over live context flags the overwrite
  assign ev[`FC_EV_FULL]      = stk_over;
  assign ev[`FC_EV_UNDER]     = stk_under;
  assign ev[`FC_EV_OVERWRITE] = int_vector & shadow_live_q;  // [RULE_07]

  assign full_clr  = wb_wr & (wb_adr_i == `FC_REG_STACK) &
                     wb_dat_i[`FC_STK_FULL_BIT];
  assign under_clr = wb_wr & (wb_adr_i == `FC_REG_STACK) &
                     wb_dat_i[`FC_STK_UNDER_BIT];

  // Flags survive soft and stack error resets; set wins over clear
  always @(posedge clk_sys) begin
    if (rst) begin
      stack_full_flag_q      <= 1'b0;
      stack_underflow_flag_q <= 1'b0;
    end else begin
      if (stk_over) begin
        stack_full_flag_q <= 1'b1;                           // [RULE_01] [RULE_02]
      end else if (full_clr) begin
        stack_full_flag_q <= 1'b0;                           // [RULE_03]
      end
      if (stk_under) begin
        stack_underflow_flag_q <= 1'b1;                      // [RULE_02]
      end else if (under_clr) begin
        stack_underflow_flag_q <= 1'b0;                      // [RULE_03]
      end
    end
  end

  // Reset request rises on the same edge that sets the flag
  always @(posedge clk_sys) begin
    if (rst) begin
      stack_reset_q <= 1'b0;
    end else begin
      stack_reset_q <= stack_error_reset_enable_q &
                       (stk_over | stk_under);               // [RULE_01] [RULE_02]
    end
  end

  always @* begin
    irq_status_d = irq_status_q;
    if (wb_wr & (wb_adr_i == `FC_REG_IRQ_CLEAR)) begin
      irq_status_d = irq_status_q & ~wb_dat_i[`FC_EV_W-1:0];
    end
    irq_status_d = irq_status_d | ev;
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      stack_error_reset_enable_q <= `FC_CTRL_RESET;
      irq_status_q               <= `FC_EV_RESET;
      irq_enable_q               <= `FC_EV_RESET;
      irq_q                      <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      irq_q        <= |(irq_status_d & irq_enable_q);
      if (wb_wr & (wb_adr_i == `FC_REG_CTRL)) begin
        stack_error_reset_enable_q <= wb_dat_i[`FC_CTRL_STACK_ERROR_RESET_ENABLE_BIT];
      end
      if (wb_wr & (wb_adr_i == `FC_REG_IRQ_ENABLE)) begin
        irq_enable_q <= wb_dat_i[`FC_EV_W-1:0];
      end
    end
  end

  always @* begin
    rd_data = 32'h00000000;
    case (wb_adr_i)
      `FC_REG_CTRL: begin
        rd_data[`FC_CTRL_STACK_ERROR_RESET_ENABLE_BIT] = stack_error_reset_enable_q;
      end
      `FC_REG_STACK: begin
        rd_data[`FC_STK_FULL_BIT]  = stack_full_flag_q;
        rd_data[`FC_STK_UNDER_BIT] = stack_underflow_flag_q;
        rd_data[`FC_STK_COUNT_LSB +: SCW] = stk_count;
      end
      `FC_REG_IRQ_STATUS: begin
        rd_data[`FC_EV_W-1:0] = irq_status_q;
      end
      `FC_REG_IRQ_ENABLE: begin
        rd_data[`FC_EV_W-1:0] = irq_enable_q;
      end
      `FC_REG_PC: begin
        rd_data[`FC_PC_W-1:0] = pc_q;
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  // One wait state slave; ack for every cycle, unmapped reads zero
  always @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req & ~wb_we_i) begin
        wb_dat_o <= wb_rd_lo ? rd_data : 32'h00000000;
      end
    end
  end

endmodule

`default_nettype wire

// ==== bench/decoder_model.sv ====
// Behavioural instruction decoder and interrupt vectoring model
`timescale 1ns/1ps
`default_nettype none
module decoder_model (
  input  wire logic [3:0]  op,
  input  wire logic [7:0]  arg,
  output logic             int_vector,
  output logic [20:0]      int_vector_addr,
  output logic             call_op,
  output logic             call_fast,
  output logic [20:0]      call_addr,
  output logic             return_op,
  output logic             return_fast,
  output logic             return_from_interrupt_op,
  output logic             return_from_interrupt_fast,
  output logic             return_with_literal_op,
  output logic [7:0]       return_with_literal_literal,
  output logic             pc_step,
  output logic             pcl_read,
  output logic             pcl_add,
  output logic [7:0]       pcl_add_offset,
  output logic             latch_high_we,
  output logic             latch_upper_we,
  output logic [7:0]       latch_wd
);
  // One operation per cycle, selected by op
  assign int_vector      = (op == 4'h1);
  assign int_vector_addr = {12'h000, arg, 1'b0};
  assign call_op         = (op == 4'h2) || (op == 4'h3);
  assign call_fast       = (op == 4'h3);
  assign call_addr       = {12'h000, arg, 1'b0};
  assign return_op       = (op == 4'h4) || (op == 4'h5);
  assign return_fast     = (op == 4'h5);
  assign return_from_interrupt_op       = (op == 4'h6) || (op == 4'h7);
  assign return_from_interrupt_fast     = (op == 4'h7);
  assign return_with_literal_op        = (op == 4'h8);
  assign return_with_literal_literal   = arg;
  assign pc_step         = (op == 4'h9);
  assign pcl_read        = (op == 4'hA);
  assign pcl_add         = (op == 4'hB);
  assign pcl_add_offset  = {arg[6:0], 1'b0};
  assign latch_high_we   = (op == 4'hC);
  assign latch_upper_we  = (op == 4'hD);
  assign latch_wd        = arg;
endmodule
`default_nettype wire

// ==== bench/fast_context_unit_properties.sv ====
// Concurrent checks on the fast context unit ports
`timescale 1ns/1ps
`default_nettype none
module fast_context_unit_properties (
  input wire logic        clk_sys, rst, soft_rst,
  input wire logic        wb_cyc_i, wb_stb_i, wb_we_i,
  input wire logic        int_vector, call_op, call_fast,
  input wire logic        return_op, return_fast, return_from_interrupt_op, return_from_interrupt_fast,
  input wire logic        return_with_literal_op, pc_step, pcl_read, pcl_add,
  input wire logic        latch_high_we, latch_upper_we,
  input wire logic [7:0]  return_with_literal_literal,
  input wire logic [20:0] pc_q,
  input wire logic [7:0]  pc_high_latch_q,
  input wire logic [4:0]  pc_upper_latch_q,
  input wire logic [7:0]  working_register_q,
  input wire logic [7:0]  status_q,
  input wire logic [3:0]  bank_select_register_q,
  input wire logic        stack_full_flag_q, stack_underflow_flag_q,
  input wire logic        stack_reset_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire        quiet = !soft_rst && !stack_reset_q;
  wire        hi    = int_vector || call_op;
  wire        pop   = return_op || return_from_interrupt_op || return_with_literal_op;
  wire [19:0] ctx   = {status_q, working_register_q, bank_select_register_q};
  wire        wbw   = wb_cyc_i && wb_stb_i && wb_we_i;
  wire        fast  = (return_op && return_fast) || (return_from_interrupt_op && return_from_interrupt_fast);
  reg  [19:0] shadow_q;
  // Reference copy of the single shadow level
  always @(posedge clk_sys) begin
    if (rst || soft_rst || stack_reset_q) shadow_q <= 20'h00000;
    else if (int_vector || (call_op && call_fast)) shadow_q <= ctx;
  end
  a_pc_even: assert property (pc_q[0] == 1'b0)
    else $error("pc bit zero set");
  a_step_by_two: assert property (pc_step && !hi && !pop && !pcl_add && quiet
    |=> pc_q == $past(pc_q) + 21'h000002)
    else $error("pc step not two");
  a_add_keeps_latch: assert property (pcl_add && !pcl_read && !latch_high_we
    && !latch_upper_we && quiet |=> $stable(pc_high_latch_q)
    && $stable(pc_upper_latch_q))
    else $error("pc add changed latches");
  a_read_loads_latch: assert property (pcl_read && quiet |=>
    pc_high_latch_q == $past(pc_q[15:8])
    && pc_upper_latch_q == $past(pc_q[20:16]))
    else $error("pc read did not load latches");
  a_return_with_literal_loads_w: assert property (return_with_literal_op && !hi && quiet |=>
    working_register_q == $past(return_with_literal_literal))
    else $error("literal return wrong working value");
  a_full_sticky: assert property ($fell(stack_full_flag_q) |->
    $past(wbw) || $past(rst))
    else $error("full flag cleared without software");
  a_under_sticky: assert property ($fell(stack_underflow_flag_q) |->
    $past(wbw) || $past(rst))
    else $error("underflow flag cleared without software");
  a_reset_after_flag: assert property (stack_reset_q |->
    stack_full_flag_q || stack_underflow_flag_q)
    else $error("stack reset without flag");
  a_fast_restore: assert property (fast && !hi && quiet |=>
    ctx == $past(shadow_q))
    else $error("fast return restored wrong context");
endmodule
bind fast_context_unit fast_context_unit_properties chk (.clk_sys, .rst,
  .soft_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .int_vector, .call_op,
  .call_fast, .return_op, .return_fast, .return_from_interrupt_op, .return_from_interrupt_fast, .return_with_literal_op,
  .pc_step, .pcl_read, .pcl_add, .latch_high_we, .latch_upper_we,
  .return_with_literal_literal, .pc_q, .pc_high_latch_q, .pc_upper_latch_q,
  .working_register_q, .status_q, .bank_select_register_q,
  .stack_full_flag_q, .stack_underflow_flag_q, .stack_reset_q);
`default_nettype wire

// ==== bench/fast_context_unit_test.sv ====
// Self-checking bench for the fast context unit
`timescale 1ns/1ps
`default_nettype none
module fast_context_unit_test;
  logic clk_sys, rst, soft_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_q;
  logic working_register_we, status_we, bsr_we, stack_reset_q, full_q, under_q;
  logic int_vector, call_op, call_fast, return_op, return_fast, return_from_interrupt_op;
  logic return_from_interrupt_fast, return_with_literal_op, pc_step, pcl_read, pcl_add, hi_we, up_we;
  logic [3:0]  op, bsr_wd, bsr_q;
  logic [7:0]  arg, wb_adr_i, working_register_wd, status_wd, w_q, st_q, hi_q, lw, ofs, lwd;
  logic [4:0]  up_q;
  logic [20:0] pc_q, iv_addr, c_addr;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  integer      num_errors, cmp_count, cycles, rst_seen, i;
  decoder_model partner (.op(op), .arg(arg), .int_vector(int_vector),
    .int_vector_addr(iv_addr), .call_op(call_op), .call_fast(call_fast),
    .call_addr(c_addr), .return_op(return_op), .return_fast(return_fast),
    .return_from_interrupt_op(return_from_interrupt_op), .return_from_interrupt_fast(return_from_interrupt_fast), .return_with_literal_op(return_with_literal_op),
    .return_with_literal_literal(lw), .pc_step(pc_step), .pcl_read(pcl_read),
    .pcl_add(pcl_add), .pcl_add_offset(ofs), .latch_high_we(hi_we),
    .latch_upper_we(up_we), .latch_wd(lwd));
  fast_context_unit DUT (.clk_sys(clk_sys), .rst(rst), .soft_rst(soft_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_vector(int_vector),
    .int_vector_addr(iv_addr), .call_op(call_op), .call_fast(call_fast),
    .call_addr(c_addr), .return_op(return_op), .return_fast(return_fast),
    .return_from_interrupt_op(return_from_interrupt_op), .return_from_interrupt_fast(return_from_interrupt_fast), .return_with_literal_op(return_with_literal_op),
    .return_with_literal_literal(lw), .pc_step(pc_step), .pcl_read(pcl_read),
    .pcl_add(pcl_add), .pcl_add_offset(ofs), .latch_high_we(hi_we),
    .latch_upper_we(up_we), .latch_wd(lwd), .working_register_we(working_register_we),
    .working_register_wd(working_register_wd), .status_we(status_we), .status_wd(status_wd),
    .bsr_we(bsr_we), .bsr_wd(bsr_wd), .pc_q(pc_q), .pc_high_latch_q(hi_q),
    .pc_upper_latch_q(up_q), .working_register_q(w_q), .status_q(st_q),
    .bank_select_register_q(bsr_q), .stack_full_flag_q(full_q),
    .stack_underflow_flag_q(under_q), .stack_reset_q(stack_reset_q),
    .irq_q(irq_q));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (stack_reset_q === 1'b1) rst_seen <= rst_seen + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end
  task complete_run();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single wishbone cycle, waits for ack
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
    wb_adr_i <= a; wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    // Write lands at the ack edge; let registered outputs follow it
    @(posedge clk_sys);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000);
    check(rdat, exp);
  endtask
  task do_op(input logic [3:0] c, input logic [7:0] a);
    @(posedge clk_sys); op <= c; arg <= a;
    @(posedge clk_sys); op <= 4'h0;
    #1;
  endtask
  task core(input logic [7:0] w, input logic [7:0] s, input logic [3:0] b);
    @(posedge clk_sys);
    working_register_we <= 1'b1; status_we <= 1'b1; bsr_we <= 1'b1;
    working_register_wd <= w; status_wd <= s; bsr_wd <= b;
    @(posedge clk_sys); working_register_we <= 1'b0; status_we <= 1'b0; bsr_we <= 1'b0;
    #1;
  endtask
  task soft_pulse();
    @(posedge clk_sys); soft_rst <= 1'b1;
    @(posedge clk_sys); soft_rst <= 1'b0;
    #1;
  endtask
  initial begin
    {rst, soft_rst, wb_cyc_i, wb_stb_i, wb_we_i, working_register_we, status_we} = 7'h01 << 6;
    {bsr_we, op, arg, wb_adr_i, working_register_wd, status_wd, bsr_wd} = 41'h0;
    wb_dat_i = 32'h0; num_errors = 0; cmp_count = 0; cycles = 0; rst_seen = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h00, 32'h00000001);
    check(pc_q, 21'h000000);
    for (i = 0; i < 3; i++) do_op(4'h9, 8'h00);
    check(pc_q, 21'h000006);
    $display("test 1 done");
    do_op(4'h1, 8'h91); do_op(4'hA, 8'h00);
    check({hi_q, 3'h0, up_q}, 16'h0100);
    do_op(4'hB, 8'h03);
    check(pc_q, 21'h000128);
    do_op(4'hC, 8'h55); do_op(4'hB, 8'h00);
    check({pc_q, hi_q}, 29'h00552855);
    soft_pulse(); core(8'h11, 8'h22, 4'h3); do_op(4'h3, 8'h40);
    core(8'h44, 8'h55, 4'h6); do_op(4'h5, 8'h00);
    check({w_q, st_q, bsr_q}, 20'h11223);
    $display("test 2 done");
    wb(1'b1, 8'h10, 32'h00000004);
    core(8'h01, 8'h01, 4'h1); do_op(4'h1, 8'h10);
    core(8'h02, 8'h02, 4'h2); do_op(4'h1, 8'h20);
    core(8'h03, 8'h03, 4'h3); do_op(4'h7, 8'h00);
    check({w_q, st_q, bsr_q}, 20'h02022);
    check(irq_q, 1'b1);
    rd(8'h08, 32'h00000004);
    wb(1'b1, 8'h10, 32'h0); check(irq_q, 1'b0);
    wb(1'b1, 8'h10, 32'h4); check(irq_q, 1'b1);
    wb(1'b1, 8'h0C, 32'h4); wb(1'b0, 8'h20, 32'h0); check(irq_q, 1'b0);
    check(rdat, 32'h0);
    do_op(4'h8, 8'hA5);
    check(w_q, 8'hA5);
    do_op(4'h1, 8'h30); core(8'h66, 8'h77, 4'h8); do_op(4'h6, 8'h00);
    check({w_q, st_q, bsr_q}, 20'h66778);
    $display("test 3 done");
    wb(1'b1, 8'h00, 32'h0);
    for (i = 0; i < 32; i++) do_op(4'h2, 8'h08);
    repeat (3) @(posedge clk_sys);
    check({full_q, under_q, rst_seen[3:0]}, 6'h20);
    rd(8'h04, 32'h00001F01);
    soft_pulse();
    check(full_q, 1'b1);
    wb(1'b1, 8'h04, 32'h1); check(full_q, 1'b0);
    wb(1'b1, 8'h00, 32'h1); do_op(4'h4, 8'h00);
    repeat (4) @(posedge clk_sys);
    check({under_q, rst_seen[3:0]}, 5'h11);
    rd(8'h04, 32'h00000002); rd(8'h08, 32'h00000003);
    $display("test 4 done");
    complete_run();
  end
endmodule
`default_nettype wire
